// >>> verilog/tcwd_defines.svh
// Constants for the terminal control word decoder.
// Summary of operation
// - Window lock refuses local opens, allows closes.
// - Window lock suppresses keyboard popup on local switch.
// - Entry lock rejects local entry and table changes.
// - Host writes and control copies ignore entry lock.
// - Screen lock blocks local switches, host switches pass.
// - Copy type bit selects numeral or text class.
// - Copy execute starts copy; host clears afterwards.
// - Control-word copies never raise notify flags.
// - Rising history-clear bit erases alarm history.
// - Status notify block is two consecutive words.
// - Only changed control bits trigger action.
// - Table numbers range 0 to 1999, BCD or hex.
`ifndef TCWD_DEFINES_SVH
`define TCWD_DEFINES_SVH
`define TCWD_OFS_SRC        2'h1
`define TCWD_OFS_DST        2'h2
`define TCWD_OFS_CTRL       2'h3
`define TCWD_BIT_WIN_LOCK   6
`define TCWD_BIT_ENTRY_LOCK 5
`define TCWD_BIT_SCR_LOCK   4
`define TCWD_BIT_COPY_EXEC  3
`define TCWD_BIT_COPY_TYPE  2
`define TCWD_BIT_HIST_CLR   1
`define TCWD_CTRL_MASK      16'h007E
`define TCWD_TABLE_MAX      16'h07CF
`define TCWD_TABLE_MAX_BCD  16'h1999
`define TCWD_RST_WORD       16'h0000
`define TCWD_NOTIFY_WORDS   2
`endif

// >>> verilog/tcwd_pkg.sv
// Types shared by the terminal control word decoder.
package tcwd_pkg;
   typedef struct packed {
      logic        numeral;   // 1 numeral class, 0 text class
      logic [15:0] src;       // Source table number
      logic [15:0] dst;       // Destination table number
   } tcwd_copy_req_t;

   typedef enum logic [2:0] {
      TCWD_IDLE = 3'b001,
      TCWD_REQ  = 3'b010,
      TCWD_DONE = 3'b100
   } tcwd_copy_state_t;
endpackage

// >>> verilog/tcwd_decoder.sv
// Terminal control word decoder: host-written words, local lock gating, copy control.
`timescale 1ns/1ps
`default_nettype none
`include "tcwd_defines.svh"
module tcwd_decoder (
   input  wire logic                    mclk,            // 100 MHz clock
   input  wire logic                    rst,             // Sync reset, active high
   input  wire logic                    host_wr,         // Host word write strobe
   input  wire logic [1:0]              host_addr,       // Word offset from control base
   input  wire logic [15:0]             host_wdata,      // Host write data
   input  wire logic                    host_rd,         // Host word read strobe
   output logic [15:0]                  host_rdata,      // Read data, registered
   input  wire logic                    numeral_bcd,     // Table numbers stored as BCD
   input  wire logic                    loc_win_open,    // Local window open request
   input  wire logic                    loc_win_close,   // Local window close request
   input  wire logic                    loc_scr_switch,  // Local screen change request
   input  wire logic                    scr_has_keybd,   // Target screen has keyboard attr
   input  wire logic                    host_scr_switch, // Host screen change request
   input  wire logic                    loc_entry,       // Local entry incl. wheel and reader
   input  wire logic                    loc_table_chg,   // Local table change, e.g. copy switch
   input  wire logic                    loc_entry_notify,// Local entry wants notify update
   output logic                         win_open_ok,     // Window open accepted
   output logic                         win_close_ok,    // Window close accepted
   output logic                         keybd_popup_ok,  // Keyboard window may pop up
   output logic                         scr_switch_ok,   // Screen change accepted
   output logic                         entry_ok,        // Local entry accepted
   output logic                         table_chg_ok,    // Local table change accepted
   output logic                         notify_set,      // Update notify flags and table word
   output logic                         copy_valid,      // Copy request to table engine
   output tcwd_pkg::tcwd_copy_req_t     copy_req,        // Copy request fields, registered
   input  wire logic                    copy_ready,      // Table engine accepts copy
   input  wire logic                    copy_done,       // Table engine finished copy
   output logic                         copy_busy,       // Copy in progress
   output logic                         copy_range_err,  // Last copy refused for range
   output logic                         alarm_hist_clr   // One-cycle alarm history erase
);
   logic [15:0]                  src_q;
   logic [15:0]                  dst_q;
   logic [15:0]                  ctrl_q;
   logic [15:0]                  prev_q;
   logic                         err_q;
   logic                         clr_q;
   tcwd_pkg::tcwd_copy_state_t   st_q;
   tcwd_pkg::tcwd_copy_state_t   st_d;
   tcwd_pkg::tcwd_copy_req_t     req_q;
   logic [15:0]                  rdata_q;

   // Status notify block size; the block itself lives outside this decoder
   localparam int NOTIFY_WORDS = `TCWD_NOTIFY_WORDS;

   // Decode of host accesses
   wire        wr_src   = host_wr && host_addr == `TCWD_OFS_SRC;
   wire        wr_dst   = host_wr && host_addr == `TCWD_OFS_DST;
   wire        wr_ctrl  = host_wr && host_addr == `TCWD_OFS_CTRL;
   wire [15:0] ctrl_new = host_wdata & `TCWD_CTRL_MASK;

   // Lock bits and edges of the action bits since the previous cycle
   wire win_lock   = ctrl_q[`TCWD_BIT_WIN_LOCK];
   wire entry_lock = ctrl_q[`TCWD_BIT_ENTRY_LOCK];
   wire scr_lock   = ctrl_q[`TCWD_BIT_SCR_LOCK];
   wire exec_rise  = ctrl_q[`TCWD_BIT_COPY_EXEC] & ~prev_q[`TCWD_BIT_COPY_EXEC];
   wire hist_rise  = ctrl_q[`TCWD_BIT_HIST_CLR] & ~prev_q[`TCWD_BIT_HIST_CLR];

   // Table number range check, BCD or hex
   function automatic logic tab_ok(input logic [15:0] n, input logic bcd);
      logic ok;
      ok = 1'b1;
      if (bcd) begin
         ok = n[3:0] <= 4'h9 && n[7:4] <= 4'h9 && n[11:8] <= 4'h9 && n <= `TCWD_TABLE_MAX_BCD;
      end else begin
         ok = n <= `TCWD_TABLE_MAX;
      end
      return ok;
   endfunction
   wire range_ok = tab_ok(src_q, numeral_bcd) && tab_ok(dst_q, numeral_bcd);

   // Local operation gating
   assign win_open_ok    = loc_win_open && !win_lock;
   assign win_close_ok   = loc_win_close;
   assign keybd_popup_ok = loc_scr_switch && scr_has_keybd && !win_lock
                           && !scr_lock;
   assign scr_switch_ok  = host_scr_switch || (loc_scr_switch && !scr_lock);
   assign entry_ok       = loc_entry && !entry_lock;
   assign table_chg_ok   = loc_table_chg && !entry_lock;
   assign notify_set     = loc_entry_notify && !entry_lock;

   // Host-written words; host writes never check the entry lock
   always_ff @(posedge mclk) begin
      if (rst) begin
         src_q  <= `TCWD_RST_WORD;
         dst_q  <= `TCWD_RST_WORD;
         ctrl_q <= `TCWD_RST_WORD;
         prev_q <= `TCWD_RST_WORD;
      end else begin
         prev_q <= ctrl_q;
         if (wr_src)  src_q  <= host_wdata;
         if (wr_dst)  dst_q  <= host_wdata;
         if (wr_ctrl) ctrl_q <= ctrl_new;
      end
   end

   // Copy sequencer, started on the rising edge of the execute bit
   always_comb begin
      st_d = st_q;
      case (st_q)
         tcwd_pkg::TCWD_IDLE: begin
            if (exec_rise && range_ok) st_d = tcwd_pkg::TCWD_REQ;
         end
         tcwd_pkg::TCWD_REQ: begin
            if (copy_ready) st_d = tcwd_pkg::TCWD_DONE;
         end
         tcwd_pkg::TCWD_DONE: begin
            if (copy_done) st_d = tcwd_pkg::TCWD_IDLE;
         end
         default: st_d = tcwd_pkg::TCWD_IDLE;
      endcase
   end

   // Sequencer state, latched request and range error
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q  <= tcwd_pkg::TCWD_IDLE;
         req_q <= '0;
         err_q <= 1'b0;
      end else begin
         st_q <= st_d;
         if (st_q == tcwd_pkg::TCWD_IDLE && exec_rise) begin
            req_q.numeral <= ctrl_q[`TCWD_BIT_COPY_TYPE];
            req_q.src     <= src_q;
            req_q.dst     <= dst_q;
            err_q         <= !range_ok;
         end
      end
   end

   // Alarm history erase pulse and read data
   always_ff @(posedge mclk) begin
      if (rst) begin
         clr_q   <= 1'b0;
         rdata_q <= `TCWD_RST_WORD;
      end else begin
         clr_q <= hist_rise;
         if (host_rd) begin
            case (host_addr)
               `TCWD_OFS_SRC:  rdata_q <= src_q;
               `TCWD_OFS_DST:  rdata_q <= dst_q;
               `TCWD_OFS_CTRL: rdata_q <= ctrl_q;
               default:        rdata_q <= {12'h000, copy_busy, err_q, 2'h0};
            endcase
         end
      end
   end

   assign copy_valid     = st_q == tcwd_pkg::TCWD_REQ;
   assign copy_busy      = st_q != tcwd_pkg::TCWD_IDLE;
   assign copy_req       = req_q;
   assign copy_range_err = err_q;
   assign alarm_hist_clr = clr_q;
   assign host_rdata     = rdata_q;
endmodule
`default_nettype wire

// >>> verification/tcwd_properties.sv
// Port checker for the control word decoder.
`timescale 1ns/1ps
`default_nettype none
module tcwd_chk (
   input wire logic        mclk,            // Clock
   input wire logic        rst,             // Reset
   input wire logic        host_wr,         // Write strobe
   input wire logic [1:0]  host_addr,       // Word offset
   input wire logic [15:0] host_wdata,      // Write data
   input wire logic        loc_win_open,    // Local open request
   input wire logic        loc_win_close,   // Local close request
   input wire logic        win_open_ok,     // Open grant
   input wire logic        win_close_ok,    // Close grant
   input wire logic        host_scr_switch, // Host screen change
   input wire logic        scr_switch_ok,   // Screen change grant
   input wire logic        keybd_popup_ok,  // Popup grant
   input wire logic        copy_valid,      // Copy request
   input wire logic        copy_ready,      // Copy accepted
   input wire logic        copy_busy,       // Copy running
   input wire logic        alarm_hist_clr   // History erase pulse
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Lock gating seen at the grants
   chk_close_free: assert property (win_close_ok == loc_win_close) else $error("close");
   chk_open_cause: assert property (win_open_ok |-> loc_win_open) else $error("open");
   chk_popup_gate: assert property (keybd_popup_ok |-> scr_switch_ok) else $error("popup");
   chk_host_switch: assert property (host_scr_switch |-> scr_switch_ok) else $error("host");
   // Copy handshake and history pulse
   chk_copy_start: assert property ($rose(copy_valid) |->
      $past(host_wr && host_addr == 2'h3 && host_wdata[3], 2)) else $error("start");
   chk_valid_hold: assert property (copy_valid && !copy_ready |=> copy_valid) else $error("hold");
   chk_busy_take: assert property (copy_valid && copy_ready |=> copy_busy && !copy_valid)
      else $error("take");
   chk_hist_pulse: assert property (alarm_hist_clr |->
      $past(host_wr && host_addr == 2'h3 && host_wdata[1], 2) ##1 !alarm_hist_clr) else $error("hist");
   cov_copy: cover property (copy_valid && copy_ready);
   cov_hist: cover property (alarm_hist_clr);
   cov_lock: cover property (loc_win_open && !win_open_ok);
endmodule
bind tcwd_decoder tcwd_chk u_chk (.mclk, .rst, .host_wr, .host_addr, .host_wdata, .loc_win_open,
   .loc_win_close, .win_open_ok, .win_close_ok, .host_scr_switch, .scr_switch_ok,
   .keybd_popup_ok, .copy_valid, .copy_ready, .copy_busy, .alarm_hist_clr);
`default_nettype wire

// >>> verification/tcwd_table_model.sv
// Table engine model answering copy requests.
`timescale 1ns/1ps
`default_nettype none
module tcwd_table_model (
   input wire logic mclk,       // Clock
   input wire logic rst,        // Reset
   input wire logic slow,       // Delay acceptance
   input wire logic copy_valid, // Copy request
   output var logic copy_ready, // Request taken
   output var logic copy_done   // Copy finished
);
   logic [3:0] wait_q;
   logic [2:0] run_q;
   // Accept after a delay, finish four cycles later
   always_ff @(posedge mclk) begin
      copy_ready <= 1'b0;
      copy_done <= 1'b0;
      if (rst) begin
         wait_q <= 4'h0;
         run_q <= 3'h0;
      end else if (copy_valid && !copy_ready) begin
         wait_q <= wait_q + 4'h1;
         if (wait_q >= (slow ? 4'h6 : 4'h0)) begin
            copy_ready <= 1'b1;
            wait_q <= 4'h0;
            run_q <= 3'h4;
         end
      end else if (run_q != 3'h0) begin
         run_q <= run_q - 3'h1;
         copy_done <= (run_q == 3'h1);
      end
   end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the control word decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        mclk = 0, rst = 1, host_wr = 0, host_rd = 0, bcd = 0, slow = 0;
   logic [1:0]  host_addr = 0;
   logic [15:0] host_wdata = 0, host_rdata;
   logic [7:0]  loc = 0;
   logic [6:0]  ok;
   logic        copy_valid, copy_ready, copy_done, copy_busy, range_err, hist;
   tcwd_pkg::tcwd_copy_req_t req;
   int          errors = 0, compares = 0;
   always #5 mclk = ~mclk;
   tcwd_decoder uut (.mclk, .rst, .host_wr, .host_addr, .host_wdata, .host_rd, .host_rdata,
      .numeral_bcd(bcd), .loc_win_open(loc[7]), .loc_win_close(loc[6]), .loc_scr_switch(loc[5]),
      .scr_has_keybd(loc[4]), .host_scr_switch(loc[3]), .loc_entry(loc[2]),
      .loc_table_chg(loc[1]), .loc_entry_notify(loc[0]), .win_open_ok(ok[6]),
      .win_close_ok(ok[5]), .keybd_popup_ok(ok[4]), .scr_switch_ok(ok[3]), .entry_ok(ok[2]),
      .table_chg_ok(ok[1]), .notify_set(ok[0]), .copy_valid, .copy_req(req), .copy_ready,
      .copy_done, .copy_busy, .copy_range_err(range_err), .alarm_hist_clr(hist));
   tcwd_table_model partner (.mclk, .rst, .slow, .copy_valid, .copy_ready, .copy_done);
   // Compare, count and close
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // One host word write, or a read compared against d; host also writes and reads status offset 0
   task automatic acc(input logic w, input logic [1:0] a, input logic [15:0] d);
      host_addr = a;
      host_wdata = d;
      host_wr = w;
      host_rd = !w;
      @(posedge mclk) #1;
      host_wr = 0;
      host_rd = 0;
      if (!w) check(host_rdata, d);
      @(posedge mclk) #1;
   endtask
   task automatic t_regs;
      acc(0, 2'h1, 16'h0000);
      acc(0, 2'h3, 16'h0000);
      acc(1, 2'h0, 16'hFFFF);
      acc(1, 2'h3, 16'hFF81);
      acc(0, 2'h3, 16'h0000);
      check({copy_valid, hist}, 2'b00);
      acc(0, 2'h0, 16'h0000);
   endtask
   task automatic t_locks;
      logic [15:0] w [5] = '{16'h0000, 16'h0040, 16'h0010, 16'h0020, 16'h0070};
      logic [6:0]  e [5] = '{7'h7F, 7'h2F, 7'h67, 7'h78, 7'h20};
      loc = 8'hF7;
      for (int i = 0; i < 5; i++) begin
         acc(1, 2'h3, w[i]);
         check(ok, e[i]);
      end
      loc = 8'hFF;
      #1 check(ok, 7'h28);
      loc = 8'h00;
   endtask
   task automatic t_copy(input logic [15:0] s, d, c, input logic exp);
      acc(1, 2'h1, s);
      acc(1, 2'h2, d);
      acc(0, 2'h1, s);
      acc(1, 2'h3, c);
      check({copy_valid, range_err, ok[0]}, {exp, !exp, 1'b0});
      if (exp) check(req, {c[2], s, d});
      for (int i = 0; i < 20 && (copy_valid || copy_busy); i++) @(posedge mclk) #1;
      check(copy_busy, 1'b0);
      if (!exp) acc(0, 2'h0, 16'h0004);
      acc(1, 2'h3, c);
      @(posedge mclk) #1;
      check(copy_valid, 1'b0);
      acc(1, 2'h3, 16'h0000);
   endtask
   task automatic t_hist;
      acc(1, 2'h3, 16'h0002);
      check(hist, 1'b1);
      @(posedge mclk) #1;
      check(hist, 1'b0);
      acc(1, 2'h3, 16'h0000);
      check(hist, 1'b0);
   endtask
   // Reset, scenarios, verdict
   initial begin
      repeat (20) @(posedge mclk);
      #1 rst = 0;
      t_regs;
      t_locks;
      t_copy(16'h0005, 16'h0007, 16'h000C, 1'b1);
      slow = 1;
      t_copy(16'h07CF, 16'h0000, 16'h0028, 1'b1);
      t_copy(16'h07D0, 16'h0001, 16'h000C, 1'b0);
      bcd = 1;
      t_copy(16'h1999, 16'h0010, 16'h000C, 1'b1);
      t_copy(16'h001A, 16'h0001, 16'h0008, 1'b0);
      t_hist;
      tally_and_finish;
   end
   // Watchdog
   initial begin
      #20000;
      errors++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
